/* tsa_core.sv */
`timescale 1ns/100ps
`include "tsa_params.svh"

module tsa_core
    import tsa_pkg::*;
#(
    parameter int unsigned WDOG_CYC = `TSA_WDOG_CYC
) (
    input  wire logic         ref_clk,        // core clock, 10 MHz
    input  wire logic         resetn,         // synchronous reset, active low
    input  wire logic         clk_en,         // freezes all state while low
    input  wire logic         wdog_timeout,   // watchdog timeout condition, level
    input  wire logic         wdog_service,   // watchdog serviced, pulse
    input  wire logic         trap_req,       // normal trap taken, pulse
    input  wire logic         software_initiated_reset, // software reset request, pulse
    input  wire logic         trap_ret,       // trap return lowers trap level, pulse
    input  wire logic         err_log_we,     // capture new error log word
    input  wire logic [63:0]  err_log_in,     // error log word
    input  wire logic         flush_req,      // instruction-cache flush, pulse
    input  tsa_asr_req_t      asr_req,        // ancillary state access
    input  tsa_fp_ld_t        fp_ld,          // floating-point load completion
    input  tsa_fp_res_t       fp_res,         // floating-point result before rounding
    output logic [2:0]        trap_level_r,   // current trap level
    output logic              fatal_err_r,    // in fatal error state
    output logic              wdog_reset_r,   // watchdog reset to processor
    output logic [63:0]       err_log_r,      // error log, kept across watchdog reset
    output logic              icache_inval_r, // hardware cache invalidate pulse
    output logic              fp_wr_en_r,     // fp register write enable
    output logic [4:0]        fp_wr_dest_r,   // fp destination register
    output logic [63:0]       fp_wr_data_r,   // fp write data
    output logic              asr_rd_valid_r, // read data valid pulse
    output logic [63:0]       asr_rd_data_r,  // read data
    output logic              priv_trap_r,    // privileged-opcode trap pulse
    output logic              underflow_r,    // underflow flag
    output logic [63:0]       extended_arith_reg_r,            // extended arithmetic register
    output logic [63:0]       extended_arith_status_reg_r,     // extended arithmetic status
    output logic [63:0]       trap_saved_extended_arith_reg_r  // written only by ancillary access, privileged
);
    tsa_state_t  state_r;
    tsa_state_t  state_nxt;
    logic [2:0]  seq_cnt_r;
    logic        wdog_expired;
    logic        any_trap;
    tsa_fields_t f;
    logic [63:0] wr_val;
    logic [63:0] imm_ext;
    logic        hit_asr;
    logic        priv_block;

    function automatic tsa_fields_t decode(input logic [31:0] ins);
        tsa_fields_t d;
        d.rd                     = ins[`TSA_RD_HI:`TSA_RD_LO];
        d.first_source_field     = ins[`TSA_SRC1_HI:`TSA_SRC1_LO];   // RL8
        d.imm                    = ins[`TSA_IMM_BIT];                // RL8
        d.rsvd                   = ins[`TSA_RSVD_HI:`TSA_RSVD_LO];
        d.second_source_field    = ins[`TSA_SRC2_HI:`TSA_SRC2_LO];   // RL8
        d.signed_immediate_field = ins[`TSA_SIMM_HI:`TSA_SIMM_LO];   // RL8
        return d;
    endfunction

    tsa_wdog #(.TIMEOUT_CYC(WDOG_CYC)) u_wdog (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .clk_en      (clk_en),
        .timeout_lvl (wdog_timeout),
        .service     (wdog_service),
        .expired_r   (wdog_expired)
    );

    assign any_trap = trap_req || software_initiated_reset;

    // ---- fatal error state sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TSA_RUN: begin
                if (wdog_expired) begin
                    state_nxt = TSA_ERR;                       // RL1
                end else if (any_trap && trap_level_r == `TSA_MAX_TRAP_LEVEL) begin
                    state_nxt = TSA_ERR;                       // RL2
                end
            end
            TSA_ERR: begin
                if (seq_cnt_r == `TSA_ERR_DELAY - `TSA_CNT_ONE) begin
                    state_nxt = TSA_WRST;                      // RL3
                end
            end
            TSA_WRST: begin
                if (seq_cnt_r == `TSA_WRST_LEN - `TSA_CNT_ONE) begin
                    state_nxt = TSA_RUN;
                end
            end
            default: state_nxt = TSA_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r      <= TSA_RUN;
            seq_cnt_r    <= `TSA_CNT_ZERO;
            fatal_err_r  <= 1'b0;
            wdog_reset_r <= 1'b0;
        end else if (clk_en) begin
            state_r      <= state_nxt;
            seq_cnt_r    <= (state_nxt != state_r) ? `TSA_CNT_ZERO : seq_cnt_r + `TSA_CNT_ONE;
            fatal_err_r  <= (state_nxt == TSA_ERR);
            wdog_reset_r <= (state_nxt == TSA_WRST);            // RL3
        end
    end

    // watchdog reset returns trap level to zero; traps are ignored outside run
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            trap_level_r <= `TSA_TRAP_LEVEL_ZERO;
        end else if (clk_en) begin
            if (state_r == TSA_WRST) begin
                trap_level_r <= `TSA_TRAP_LEVEL_ZERO;
            end else if (state_r == TSA_RUN && state_nxt == TSA_RUN) begin
                if (any_trap) begin
                    trap_level_r <= trap_level_r + `TSA_TRAP_LEVEL_ONE;
                end else if (trap_ret && trap_level_r != `TSA_TRAP_LEVEL_ZERO) begin
                    trap_level_r <= trap_level_r - `TSA_TRAP_LEVEL_ONE;
                end
            end
        end
    end

    // only power-on reset clears the log, so it reads back after a restart
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            err_log_r <= `TSA_LOG_RESET;
        end else if (clk_en && err_log_we) begin
            err_log_r <= err_log_in;                           // RL4
        end
    end

    // flush handled here in one cycle, no emulation trap path exists
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            icache_inval_r <= 1'b0;
        end else if (clk_en) begin
            icache_inval_r <= flush_req;                       // RL5
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fp_wr_en_r   <= 1'b0;
            fp_wr_dest_r <= 5'h0;
            fp_wr_data_r <= `TSA_REG_RESET;
        end else if (clk_en) begin
            fp_wr_en_r   <= fp_ld.valid && !fp_ld.access_err;   // RL6
            fp_wr_dest_r <= fp_ld.dest;
            fp_wr_data_r <= fp_ld.data;
        end
    end

    // tininess is taken from the exponent before rounding, never after
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            underflow_r <= 1'b0;
        end else if (clk_en) begin
            underflow_r <= fp_res.valid && fp_res.inexact
                           && (fp_res.exp_unrounded < `TSA_UF_MIN_EXP); // RL12
        end
    end

    // ---- ancillary state access; reserved bits are decoded but never checked
    assign f          = decode(asr_req.instr);                  // RL11
    assign hit_asr    = asr_req.valid && (f.rd >= `TSA_ASR_EXT_ARITH);
    assign priv_block = (f.rd == `TSA_ASR_TRAP_SAVED) && !asr_req.priv; // RL10
    assign imm_ext    = {{(`TSA_XLEN - `TSA_SIMM_HI - 1){f.signed_immediate_field[`TSA_SIMM_SIGN]}},
                         f.signed_immediate_field};
    assign wr_val     = asr_req.first_src_val
                        ^ (f.imm ? imm_ext : asr_req.second_src_val); // RL9

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            extended_arith_reg_r            <= `TSA_REG_RESET;
            extended_arith_status_reg_r     <= `TSA_REG_RESET;
            trap_saved_extended_arith_reg_r <= `TSA_REG_RESET;
        end else if (clk_en && hit_asr && asr_req.is_write && !priv_block) begin
            case (f.rd)
                `TSA_ASR_EXT_ARITH:  extended_arith_reg_r            <= wr_val; // RL9
                `TSA_ASR_EXT_STATUS: extended_arith_status_reg_r     <= wr_val; // RL9
                `TSA_ASR_TRAP_SAVED: trap_saved_extended_arith_reg_r <= wr_val; // RL9
                default:             extended_arith_reg_r            <= extended_arith_reg_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            asr_rd_valid_r <= 1'b0;
            asr_rd_data_r  <= `TSA_REG_RESET;
            priv_trap_r    <= 1'b0;
        end else if (clk_en) begin
            asr_rd_valid_r <= hit_asr && !asr_req.is_write && !priv_block; // RL7
            priv_trap_r    <= hit_asr && priv_block;            // RL13
            if (hit_asr && !asr_req.is_write && !priv_block) begin
                case (f.rd)
                    `TSA_ASR_EXT_ARITH:  asr_rd_data_r <= extended_arith_reg_r;        // RL7
                    `TSA_ASR_EXT_STATUS: asr_rd_data_r <= extended_arith_status_reg_r; // RL7
                    default:             asr_rd_data_r <= trap_saved_extended_arith_reg_r; // RL7
                endcase
            end
        end
    end

    // ---- checks, sampled only with the clock enable high
    sequence s_err_entry;
        $rose(fatal_err_r);
    endsequence
    sequence s_wrst_pulse;
        wdog_reset_r [*2] ##1 !wdog_reset_r;
    endsequence

    a_trap_max_fatal: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL2
        state_r == TSA_RUN && !wdog_expired && any_trap
        && trap_level_r == `TSA_MAX_TRAP_LEVEL
        |=> fatal_err_r)
        else $error("trap at max trap level did not enter fatal state");
    a_wdog_fatal: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL1
        state_r == TSA_RUN && wdog_expired |=> fatal_err_r)
        else $error("watchdog expiry did not enter fatal state");
    a_fatal_reset: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL3
        s_err_entry |-> fatal_err_r [*4] ##1 s_wrst_pulse)
        else $error("fatal state did not yield a two-cycle watchdog reset");
    a_log_kept: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL4
        !err_log_we |=> err_log_r == $past(err_log_r))
        else $error("error log changed without a capture");
    a_flush_hw: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL5
        flush_req |=> icache_inval_r && !priv_trap_r)
        else $error("flush not executed in hardware");
    a_fp_no_write: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL6
        fp_ld.valid && fp_ld.access_err |=> !fp_wr_en_r)
        else $error("fp load with access error wrote its destination");
    a_asr_xor: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL9
        hit_asr && asr_req.is_write && f.rd == `TSA_ASR_EXT_ARITH
        |=> extended_arith_reg_r == $past(wr_val))
        else $error("write did not store the exclusive-or result");
    a_rsvd_read: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL11
        hit_asr && !asr_req.is_write && f.rsvd != 8'h0 && f.rd != `TSA_ASR_TRAP_SAVED
        |=> asr_rd_valid_r && !priv_trap_r)
        else $error("nonzero reserved field blocked a read");
    a_saved_guard: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL13
        hit_asr && f.rd == `TSA_ASR_TRAP_SAVED && !asr_req.priv
        |=> priv_trap_r && !asr_rd_valid_r
            && trap_saved_extended_arith_reg_r == $past(trap_saved_extended_arith_reg_r))
        else $error("nonprivileged access reached the trap-saved register");
    a_open_regs: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL10
        hit_asr && f.rd != `TSA_ASR_TRAP_SAVED && !asr_req.priv |=> !priv_trap_r)
        else $error("open register trapped in nonprivileged mode");
    a_uf_preround: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en) // RL12
        fp_res.valid && fp_res.inexact && fp_res.exp_unrounded < `TSA_UF_MIN_EXP
        |=> underflow_r)
        else $error("tiny unrounded result not flagged as underflow");
endmodule

/* tsa_params.svh */
// Operation
// [RL1] enter fatal error state after watchdog timeout persists 6.7 s unserviced
// [RL2] normal trap or software reset at trap level 5 enters fatal error state
// [RL3] fatal error state produces a watchdog reset that restarts the processor
// [RL4] error-logging contents survive fatal error entry and the watchdog reset
// [RL5] instruction-cache flush runs fully in hardware, never traps for emulation
// [RL6] floating-point load with access error leaves destination registers unmodified
// [RL7] ancillary read with destination 29-31 returns the three extended registers
// [RL8] fields: 18:14 first source, 13 immediate flag, 12:5 reserved, 4:0 second source
// [RL9] ancillary write to 29-31 stores first source xor second source or immediate
// [RL10] only trap-saved extended register is privileged, other two are open
// [RL11] nonzero reserved field never raises illegal-opcode exception
// [RL12] underflow is judged on the result before rounding
// [RL13] nonprivileged access to trap-saved register traps and leaves it unchanged
`ifndef TSA_PARAMS_SVH
`define TSA_PARAMS_SVH

`define TSA_XLEN            64
`define TSA_MAX_TRAP_LEVEL  3'h5
`define TSA_TRAP_LEVEL_ZERO 3'h0
`define TSA_TRAP_LEVEL_ONE  3'h1
`define TSA_ASR_EXT_ARITH   5'h1d
`define TSA_ASR_EXT_STATUS  5'h1e
`define TSA_ASR_TRAP_SAVED  5'h1f
`define TSA_RD_HI           29
`define TSA_RD_LO           25
`define TSA_SRC1_HI         18
`define TSA_SRC1_LO         14
`define TSA_IMM_BIT         13
`define TSA_RSVD_HI         12
`define TSA_RSVD_LO         5
`define TSA_SRC2_HI         4
`define TSA_SRC2_LO         0
`define TSA_SIMM_HI         12
`define TSA_SIMM_LO         0
`define TSA_SIMM_SIGN       12
`define TSA_REG_RESET       64'h0
`define TSA_LOG_RESET       64'h0
`define TSA_CLK_KHZ         10000
`define TSA_WDOG_TIMEOUT_MS 6700
`define TSA_WDOG_CYC        (`TSA_WDOG_TIMEOUT_MS * `TSA_CLK_KHZ)
`define TSA_ERR_DELAY       3'h4
`define TSA_WRST_LEN        3'h2
`define TSA_CNT_ZERO        3'h0
`define TSA_CNT_ONE         3'h1
`define TSA_UF_MIN_EXP      13'sh1

`endif

/* tsa_pkg.sv */
package tsa_pkg;

    typedef enum logic [2:0] {
        TSA_RUN  = 3'b001,
        TSA_ERR  = 3'b010,
        TSA_WRST = 3'b100
    } tsa_state_t;

    typedef struct packed {
        logic        valid;
        logic        is_write;
        logic        priv;
        logic [31:0] instr;
        logic [63:0] first_src_val;
        logic [63:0] second_src_val;
    } tsa_asr_req_t;

    typedef struct packed {
        logic [4:0]  rd;
        logic [4:0]  first_source_field;
        logic        imm;
        logic [7:0]  rsvd;
        logic [4:0]  second_source_field;
        logic [12:0] signed_immediate_field;
    } tsa_fields_t;

    typedef struct packed {
        logic        valid;
        logic        access_err;
        logic [4:0]  dest;
        logic [63:0] data;
    } tsa_fp_ld_t;

    typedef struct packed {
        logic               valid;
        logic               inexact;
        logic signed [12:0] exp_unrounded;
    } tsa_fp_res_t;

endpackage

/* tsa_wdog.sv */
`timescale 1ns/100ps
`include "tsa_params.svh"

module tsa_wdog
    import tsa_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `TSA_WDOG_CYC
) (
    input  wire logic ref_clk,      // core clock
    input  wire logic resetn,       // synchronous reset, active low
    input  wire logic clk_en,       // freezes state while low
    input  wire logic timeout_lvl,  // watchdog timeout condition present
    input  wire logic service,      // software serviced the watchdog
    output logic      expired_r     // timeout has lasted the full period
);
    logic [31:0] cnt_r;

    // counts only while the timeout persists; servicing restarts the period
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_r     <= 32'h0;
            expired_r <= 1'b0;
        end else if (clk_en) begin
            if (service || !timeout_lvl) begin
                cnt_r     <= 32'h0;
                expired_r <= 1'b0;
            end else if (cnt_r >= TIMEOUT_CYC - 32'h1) begin
                expired_r <= 1'b1; // RL1
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
endmodule

/* trap_state_and_asr_access_tb.sv */
`timescale 1ns/100ps

module trap_state_and_asr_access_tb;
    import tsa_pkg::*;

    localparam int unsigned WDOG_SIM = 20;  // shortened watchdog period for simulation

    logic         ref_clk;
    logic         resetn;
    logic         clk_en;
    logic         wdog_timeout;
    logic         wdog_service;
    logic [4:0]   pulses;       // one bit per pulse input except wdog_service, driven by the pulse task
    logic         trap_req;
    logic         software_initiated_reset;
    logic         trap_ret;
    logic         err_log_we;
    logic [63:0]  err_log_in;
    logic         flush_req;
    tsa_asr_req_t asr_req;
    tsa_fp_ld_t   fp_ld;
    tsa_fp_res_t  fp_res;
    logic [2:0]   trap_level_r;
    logic         fatal_err_r;
    logic         wdog_reset_r;
    logic [63:0]  err_log_r;
    logic         icache_inval_r;
    logic         fp_wr_en_r;
    logic [4:0]   fp_wr_dest_r;
    logic [63:0]  fp_wr_data_r;
    logic         asr_rd_valid_r;
    logic [63:0]  asr_rd_data_r;
    logic         priv_trap_r;
    logic         underflow_r;
    logic [63:0]  extended_arith_reg_r;
    logic [63:0]  extended_arith_status_reg_r;
    logic [63:0]  trap_saved_extended_arith_reg_r;
    int           fails;
    int           comparisons;

    localparam logic [4:0] P_TRAP  = 5'h01;
    localparam logic [4:0] P_SWRST = 5'h02;
    localparam logic [4:0] P_RET   = 5'h04;
    localparam logic [4:0] P_LOG   = 5'h08;
    localparam logic [4:0] P_FLUSH = 5'h10;

    assign {flush_req, err_log_we, trap_ret, software_initiated_reset, trap_req} = pulses;

    tsa_core #(.WDOG_CYC(WDOG_SIM)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .wdog_timeout(wdog_timeout), .wdog_service(wdog_service),
        .trap_req(trap_req), .software_initiated_reset(software_initiated_reset),
        .trap_ret(trap_ret),
        .err_log_we(err_log_we), .err_log_in(err_log_in), .flush_req(flush_req),
        .asr_req(asr_req), .fp_ld(fp_ld), .fp_res(fp_res),
        .trap_level_r(trap_level_r), .fatal_err_r(fatal_err_r),
        .wdog_reset_r(wdog_reset_r), .err_log_r(err_log_r),
        .icache_inval_r(icache_inval_r), .fp_wr_en_r(fp_wr_en_r),
        .fp_wr_dest_r(fp_wr_dest_r), .fp_wr_data_r(fp_wr_data_r),
        .asr_rd_valid_r(asr_rd_valid_r), .asr_rd_data_r(asr_rd_data_r),
        .priv_trap_r(priv_trap_r), .underflow_r(underflow_r),
        .extended_arith_reg_r(extended_arith_reg_r),
        .extended_arith_status_reg_r(extended_arith_status_reg_r),
        .trap_saved_extended_arith_reg_r(trap_saved_extended_arith_reg_r)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one access; bits 24:19 carry an arbitrary opcode pattern
    task automatic asr(input logic wr, input logic pr, input logic [4:0] rd, input logic imm,
                       input logic [12:0] low, input logic [63:0] a, input logic [63:0] b);
        @(posedge ref_clk);
        asr_req <= '{1'b1, wr, pr, {2'b10, rd, 6'h30, 5'h03, imm, low}, a, b};
        @(posedge ref_clk);
        asr_req.valid <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic [4:0] sel);
        @(posedge ref_clk);
        pulses <= sel;
        @(posedge ref_clk);
        pulses <= 5'h0;
        #1;
    endtask

    task automatic test_asr();
        logic [63:0] exp_v [3];
        asr(1'b1, 1'b0, 5'h1d, 1'b1, 13'h1fff, 64'h0f, 64'h0);
        chk(extended_arith_reg_r, 64'hffff_ffff_ffff_fff0, "ext arith imm write");
        chk(priv_trap_r, 1'b0, "xar open write");
        // reserved bits 12:5 nonzero, second source form
        asr(1'b1, 1'b0, 5'h1e, 1'b0, {8'hab, 5'h02}, 64'h1234, 64'h00ff);
        chk(extended_arith_status_reg_r, 64'h12cb, "ext status reg write");
        chk(priv_trap_r, 1'b0, "reserved field write");
        asr(1'b1, 1'b1, 5'h1f, 1'b1, 13'h0005, 64'h100, 64'hdead);
        chk(trap_saved_extended_arith_reg_r, 64'h105, "saved reg priv write");
        asr(1'b1, 1'b0, 5'h1f, 1'b1, 13'h0000, 64'h77, 64'h0);
        chk(priv_trap_r, 1'b1, "saved reg user write trap");
        chk(trap_saved_extended_arith_reg_r, 64'h105, "saved reg unchanged");
        exp_v = '{64'hffff_ffff_ffff_fff0, 64'h12cb, 64'h105};
        for (int i = 0; i < 3; i++) begin
            asr(1'b0, (i == 2), 5'(29 + i), 1'b0, 13'h1fe3, 64'h0, 64'h0);
            chk(asr_rd_valid_r, 1'b1, "read valid");
            chk(asr_rd_data_r, exp_v[i], "read data");
            chk(priv_trap_r, 1'b0, "read no trap");
        end
        asr(1'b0, 1'b0, 5'h1f, 1'b0, 13'h0, 64'h0, 64'h0);
        chk(priv_trap_r, 1'b1, "saved reg user read trap");
        chk(asr_rd_valid_r, 1'b0, "saved reg user read refused");
    endtask

    task automatic test_fatal();
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            err_log_in <= 64'hc0de_0000_0000_0000 + 64'(k);
            pulse(P_LOG);
            for (int i = 0; i < 5; i++)
                pulse(P_TRAP);
            chk(trap_level_r, 3'h5, "trap level at max");
            pulse(P_RET);
            chk(trap_level_r, 3'h4, "trap return");
            pulse(P_TRAP);
            chk(fatal_err_r, 1'b0, "no fatal below max");
            // the final event is a normal trap first, then a software reset
            if (k == 0)
                pulse(P_TRAP);
            else
                pulse(P_SWRST);
            chk(fatal_err_r, 1'b1, "fatal at max level");
            pulse(P_TRAP);
            chk(trap_level_r, 3'h5, "trap ignored in fatal");
            repeat (2) @(posedge ref_clk);
            #1;
            chk(wdog_reset_r, 1'b1, "watchdog reset raised");
            chk(fatal_err_r, 1'b0, "fatal ends");
            @(posedge ref_clk);
            #1;
            chk(trap_level_r, 3'h0, "restart level");
            @(posedge ref_clk);
            #1;
            chk(wdog_reset_r, 1'b0, "watchdog reset width");
            chk(err_log_r, 64'hc0de_0000_0000_0000 + 64'(k), "log kept");
            chk(extended_arith_reg_r, 64'hffff_ffff_ffff_fff0, "ext arith kept");
        end
    endtask

    task automatic test_wdog();
        int hit;
        hit = -1;
        @(posedge ref_clk);
        wdog_timeout <= 1'b1;
        for (int i = 1; i <= 60 && hit < 0; i++) begin
            @(posedge ref_clk);
            wdog_service <= (i == 10);
            #1;
            if (fatal_err_r === 1'b1)
                hit = i;
        end
        @(posedge ref_clk);
        wdog_timeout <= 1'b0;
        // service sampled at edge 11 restarts the period
        chk(hit >= 11 + WDOG_SIM && hit <= 14 + WDOG_SIM, 1'b1, "watchdog expiry time");
        repeat (8) @(posedge ref_clk);
        #1;
        chk(fatal_err_r | wdog_reset_r, 1'b0, "watchdog sequence over");
    endtask

    task automatic test_misc();
        // a dropped clock enable must swallow the request entirely
        @(posedge ref_clk);
        clk_en <= 1'b0;
        pulse(P_FLUSH);
        chk(icache_inval_r, 1'b0, "clock enable freezes flush");
        @(posedge ref_clk);
        clk_en <= 1'b1;
        pulse(P_FLUSH);
        chk(icache_inval_r, 1'b1, "flush in hardware");
        @(posedge ref_clk);
        #1;
        chk(icache_inval_r, 1'b0, "flush pulse width");
        @(posedge ref_clk);
        fp_ld <= '{1'b1, 1'b1, 5'h03, 64'hbad};
        @(posedge ref_clk);
        fp_ld <= '{1'b1, 1'b0, 5'h07, 64'h600d};
        #1;
        chk(fp_wr_en_r, 1'b0, "access error no write");
        @(posedge ref_clk);
        fp_ld <= '0;
        fp_res <= '{1'b1, 1'b1, 13'sh0};
        #1;
        chk(fp_wr_en_r, 1'b1, "fp write enable");
        chk(fp_wr_dest_r, 5'h07, "fp write dest");
        chk(fp_wr_data_r, 64'h600d, "fp write data");
        @(posedge ref_clk);
        fp_res <= '{1'b1, 1'b1, 13'sh1};
        #1;
        chk(underflow_r, 1'b1, "underflow before rounding");
        @(posedge ref_clk);
        fp_res <= '0;
        #1;
        chk(underflow_r, 1'b0, "no underflow in range");
    endtask

    initial begin
        fails = 0;
        comparisons = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        {wdog_timeout, wdog_service} = '0;
        pulses = '0;
        err_log_in = '0;
        asr_req = '0;
        fp_ld = '0;
        fp_res = '0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        test_asr();
        test_fatal();
        test_wdog();
        test_misc();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("[ERR] %0t run limit reached", $time);
        stop_test();
    end

endmodule
